// File: hdl/icv_pkg.sv
/*
  icv_pkg: constants, types and vector map for the interrupt classify/vector unit.
  Assumes a 20-bit address space and a 32-entry maskable request set.
*/
package icv_pkg;

    // =========================================================
    // widths and counts
    localparam int ICV_ADDR_W = 20;
    localparam int ICV_NUM_SRC = 32;
    localparam logic [5:0] ICV_SW_FIRST_KEEP_U = 6'h20;
    localparam logic [31:0] ICV_VEC_BLANK = 32'hFFFF_FFFF;

    // =========================================================
    // fixed vector addresses
    localparam logic [19:0] ICV_VEC_UNDEF = 20'hF_FFDC;
    localparam logic [19:0] ICV_VEC_OVF = 20'hF_FFE0;
    localparam logic [19:0] ICV_VEC_BRK = 20'hF_FFE4;
    localparam logic [19:0] ICV_VEC_AMATCH = 20'hF_FFE8;
    localparam logic [19:0] ICV_VEC_STEP = 20'hF_FFEC;
    localparam logic [19:0] ICV_VEC_WDT = 20'hF_FFF0;
    localparam logic [19:0] ICV_VEC_DBG = 20'hF_FFF4;
    localparam logic [19:0] ICV_VEC_RESET = 20'hF_FFFC;

    // =========================================================
    // relocatable table: 256 bytes, 4 bytes per entry
    localparam int ICV_TABLE_BYTES = 256;
    localparam int ICV_ENTRY_BYTES = 4;

    // =========================================================
    // maskable source numbers
    localparam logic [4:0] ICV_NUM_KEY = 5'h0D;
    localparam logic [4:0] ICV_NUM_ADC = 5'h0E;
    localparam logic [4:0] ICV_NUM_S0_TX = 5'h11;
    localparam logic [4:0] ICV_NUM_S0_RX = 5'h12;
    localparam logic [4:0] ICV_NUM_S1_TX = 5'h13;
    localparam logic [4:0] ICV_NUM_S1_RX = 5'h14;
    localparam logic [4:0] ICV_NUM_TA0 = 5'h15;
    localparam logic [4:0] ICV_NUM_TX0 = 5'h16;
    localparam logic [4:0] ICV_NUM_TX1 = 5'h17;
    localparam logic [4:0] ICV_NUM_TX2 = 5'h18;
    localparam logic [4:0] ICV_NUM_TB0 = 5'h1A;
    localparam logic [4:0] ICV_NUM_TB1 = 5'h1B;
    localparam logic [4:0] ICV_NUM_EXT0 = 5'h1D;
    localparam logic [4:0] ICV_NUM_EXT1 = 5'h1E;

    // =========================================================
    // priority levels loaded on acceptance of watchdog and reset, and the per-source level loaded at reset
    localparam logic [2:0] ICV_IPL_WDT = 3'h7;
    localparam logic [2:0] ICV_IPL_RESET = 3'h0;
    localparam logic [2:0] ICV_LEVEL_RESET = 3'h0;

    // =========================================================
    // types
    typedef enum logic [3:0] {
        ICV_KIND_RESET, ICV_KIND_WDT, ICV_KIND_DBG, ICV_KIND_UNDEF, ICV_KIND_OVF,
        ICV_KIND_BRK, ICV_KIND_SWINT, ICV_KIND_STEP, ICV_KIND_AMATCH, ICV_KIND_MASKABLE
    } icv_kind_t;

    typedef struct packed {
        logic [2:0] processor_priority_level;
        logic u;
        logic i;
        logic d;
    } icv_flags_t;

    localparam icv_flags_t ICV_FLAGS_RESET = '{processor_priority_level: 3'h0, u: 1'b0, i: 1'b0, d: 1'b0};

    typedef struct packed {
        logic adc;
        logic s0_tx;
        logic s0_rx;
        logic s1_tx;
        logic s1_rx;
        logic tmr_a0;
        logic [2:0] tmr_x;
        logic [1:0] tmr_b;
    } icv_periph_evt_t;

    typedef struct packed {
        logic valid;
        icv_kind_t kind;
        logic [5:0] num;
        logic [2:0] level;
        logic [19:0] vector;
    } icv_offer_t;

endpackage : icv_pkg

// File: hdl/icv_unit.sv
/*
  icv_unit: interrupt classification, maskable gating, vector selection and
  stack-select handling in front of the cpu core.
  Assumes cpu-side strobes are single-cycle pulses on ref_clk; pins are asynchronous.
*/
module icv_unit
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // external pins, asynchronous
    input wire logic reset_pin_n,
    input wire logic key_input_pin_n,
    input wire logic ext_pin_irq_0,
    input wire logic ext_pin_irq_1,
    input wire logic [1:0] ext_edge_rising,
    // peripheral, watchdog and debugger event pulses
    input wire icv_pkg::icv_periph_evt_t periph_evt,
    input wire logic watchdog_evt,
    input wire logic debugger_break_irq,
    // cpu instruction events
    input wire logic instr_done,
    input wire logic undefined_opcode_instr,
    input wire logic ovf_trap_instr,
    input wire logic overflow_flag,
    input wire logic break_instr,
    input wire logic [31:0] break_vector_word,
    input wire logic sw_int_instr,
    input wire logic [5:0] sw_int_num,
    input wire logic return_instr,
    // instruction fetch and address match setup
    input wire logic fetch_valid,
    input wire logic fetch_first_byte,
    input wire logic [19:0] fetch_addr,
    input wire logic match_enable,
    input wire logic [19:0] match_addr,
    // vector table base
    input wire logic [19:0] vector_table_base,
    // flag register access
    input wire logic flag_wr,
    input wire icv_pkg::icv_flags_t flag_wdata,
    output icv_pkg::icv_flags_t processor_flag_register,
    // per-source control access
    input wire logic ctl_wr,
    input wire logic [4:0] ctl_num,
    input wire logic [2:0] ctl_level,
    input wire logic ctl_req,
    output logic [31:0] request_bits,
    // offer to the cpu
    output logic irq_valid,
    input wire logic irq_ack,
    output icv_pkg::icv_kind_t irq_kind,
    output logic [5:0] irq_num,
    output logic [2:0] irq_level,
    output logic [19:0] irq_vector
);
    import icv_pkg::*;

    // =========================================================
    // state
    typedef struct packed {
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic [1:0] ext_prev;
        logic pend_reset;
        logic pend_wdt;
        logic pend_dbg;
        logic pend_undef;
        logic pend_ovf;
        logic pend_brk;
        logic pend_sw;
        logic [5:0] sw_num;
        logic pend_step;
        logic pend_amatch;
        logic [31:0] req;
        logic [31:0][2:0] level;
        icv_flags_t flags;
        icv_flags_t saved;
        icv_offer_t offer;
    } icv_state_t;

    icv_state_t s;
    icv_state_t next_s;

    // =========================================================
    // helpers
    function automatic logic [19:0] icv_reloc_vec(input logic [19:0] base, input logic [5:0] num);
        icv_reloc_vec = base + {12'h000, num, 2'b00};
    endfunction : icv_reloc_vec

    function automatic logic [5:0] icv_pick(input logic [31:0] req, input logic [31:0][2:0] lvl,
                                            input logic [2:0] processor_priority_level);
        logic found;
        logic [2:0] best;
        logic [4:0] bn;
        found = 1'b0;
        best = 3'h0;
        bn = 5'h00;
        // descending scan with >= leaves the lowest number on a tie
        for (int k = ICV_NUM_SRC - 1; k >= 0; k--)
        begin
            if (req[k] && (lvl[k] > processor_priority_level) && (!found || lvl[k] >= best))
            begin
                found = 1'b1;
                best = lvl[k];
                bn = k[4:0];
            end
        end
        icv_pick = {found, bn};
    endfunction : icv_pick

    // =========================================================
    // next state
    always_comb
    begin
        logic [31:0] set_req;
        logic [5:0] pick;
        logic take;
        icv_offer_t cand;
        next_s = s;
        set_req = 32'h0000_0000;
        pick = 6'h00;
        take = irq_ack && s.offer.valid;
        cand = s.offer;

        // pin synchronisers: reset, key, ext0, ext1
        next_s.sync1 = {ext_pin_irq_1, ext_pin_irq_0, key_input_pin_n, reset_pin_n};
        next_s.sync2 = s.sync1;
        next_s.ext_prev = s.sync2[3:2];

        // peripheral request sources
        set_req[ICV_NUM_KEY] = !s.sync2[1];
        set_req[ICV_NUM_ADC] = periph_evt.adc;
        set_req[ICV_NUM_S0_TX] = periph_evt.s0_tx;
        set_req[ICV_NUM_S0_RX] = periph_evt.s0_rx;
        set_req[ICV_NUM_S1_TX] = periph_evt.s1_tx;
        set_req[ICV_NUM_S1_RX] = periph_evt.s1_rx;
        set_req[ICV_NUM_TA0] = periph_evt.tmr_a0;
        set_req[ICV_NUM_TX0] = periph_evt.tmr_x[0];
        set_req[ICV_NUM_TX1] = periph_evt.tmr_x[1];
        set_req[ICV_NUM_TX2] = periph_evt.tmr_x[2];
        set_req[ICV_NUM_TB0] = periph_evt.tmr_b[0];
        set_req[ICV_NUM_TB1] = periph_evt.tmr_b[1];
        set_req[ICV_NUM_EXT0] = ext_edge_rising[0] ? (s.sync2[2] && !s.ext_prev[0])
                                                   : (!s.sync2[2] && s.ext_prev[0]);
        set_req[ICV_NUM_EXT1] = ext_edge_rising[1] ? (s.sync2[3] && !s.ext_prev[1])
                                                   : (!s.sync2[3] && s.ext_prev[1]);

        // software access to control and flags
        if (ctl_wr)
        begin
            next_s.level[ctl_num] = ctl_level;
            if (!ctl_req)
                next_s.req[ctl_num] = 1'b0;
        end
        if (flag_wr)
            next_s.flags = flag_wdata;
        if (return_instr)
            next_s.flags = s.saved;

        // acceptance side effects
        if (take)
        begin
            next_s.saved = s.flags;
            // acceptance wins over a same-cycle flag write or return
            next_s.flags = s.flags;
            next_s.flags.i = 1'b0;
            next_s.flags.d = 1'b0;
            if (!(s.offer.kind == ICV_KIND_SWINT && s.offer.num >= ICV_SW_FIRST_KEEP_U))
                next_s.flags.u = 1'b0;
            unique case (s.offer.kind)
                ICV_KIND_RESET:
                begin
                    next_s.pend_reset = 1'b0;
                    next_s.flags.processor_priority_level = ICV_IPL_RESET;
                end
                ICV_KIND_WDT:
                begin
                    next_s.pend_wdt = 1'b0;
                    next_s.flags.processor_priority_level = ICV_IPL_WDT;
                end
                ICV_KIND_DBG: next_s.pend_dbg = 1'b0;
                ICV_KIND_UNDEF: next_s.pend_undef = 1'b0;
                ICV_KIND_OVF: next_s.pend_ovf = 1'b0;
                ICV_KIND_BRK: next_s.pend_brk = 1'b0;
                ICV_KIND_SWINT: next_s.pend_sw = 1'b0;
                ICV_KIND_STEP: next_s.pend_step = 1'b0;
                ICV_KIND_AMATCH: next_s.pend_amatch = 1'b0;
                ICV_KIND_MASKABLE:
                begin
                    next_s.req[s.offer.num[4:0]] = 1'b0;
                    next_s.flags.processor_priority_level = s.offer.level;
                end
            endcase
        end

        // new events after the clears, so a set in the same cycle wins
        next_s.req = next_s.req | set_req;
        if (!s.sync2[0])
            next_s.pend_reset = 1'b1;
        if (watchdog_evt)
            next_s.pend_wdt = 1'b1;
        if (debugger_break_irq)
            next_s.pend_dbg = 1'b1;
        if (undefined_opcode_instr)
            next_s.pend_undef = 1'b1;
        if (ovf_trap_instr && overflow_flag)
            next_s.pend_ovf = 1'b1;
        if (break_instr)
            next_s.pend_brk = 1'b1;
        if (sw_int_instr)
        begin
            next_s.pend_sw = 1'b1;
            next_s.sw_num = sw_int_num;
        end
        if (instr_done && s.flags.d)
            next_s.pend_step = 1'b1;
        if (match_enable && fetch_valid && fetch_first_byte && fetch_addr == match_addr)
            next_s.pend_amatch = 1'b1;

        // offer selection: special and software kinds bypass the gate
        pick = icv_pick(s.req, s.level, s.flags.processor_priority_level);
        cand = '{valid: 1'b1, kind: ICV_KIND_RESET, num: 6'h00, level: 3'h0, vector: ICV_VEC_RESET};
        if (s.pend_reset)
            cand.kind = ICV_KIND_RESET;
        else if (s.pend_wdt)
        begin
            cand.kind = ICV_KIND_WDT;
            cand.vector = ICV_VEC_WDT;
        end
        else if (s.pend_dbg)
        begin
            cand.kind = ICV_KIND_DBG;
            cand.vector = ICV_VEC_DBG;
        end
        else if (s.pend_undef)
        begin
            cand.kind = ICV_KIND_UNDEF;
            cand.vector = ICV_VEC_UNDEF;
        end
        else if (s.pend_ovf)
        begin
            cand.kind = ICV_KIND_OVF;
            cand.vector = ICV_VEC_OVF;
        end
        else if (s.pend_brk)
        begin
            cand.kind = ICV_KIND_BRK;
            cand.vector = (break_vector_word == ICV_VEC_BLANK) ? icv_reloc_vec(vector_table_base, 6'h00)
                                                             : ICV_VEC_BRK;
        end
        else if (s.pend_sw)
        begin
            cand.kind = ICV_KIND_SWINT;
            cand.num = s.sw_num;
            cand.vector = icv_reloc_vec(vector_table_base, s.sw_num);
        end
        else if (s.pend_step)
        begin
            cand.kind = ICV_KIND_STEP;
            cand.vector = ICV_VEC_STEP;
        end
        else if (s.pend_amatch)
        begin
            cand.kind = ICV_KIND_AMATCH;
            cand.vector = ICV_VEC_AMATCH;
        end
        else
        begin
            cand.kind = ICV_KIND_MASKABLE;
            cand.valid = s.flags.i && pick[5];
            cand.num = {1'b0, pick[4:0]};
            cand.level = s.level[pick[4:0]];
            cand.vector = icv_reloc_vec(vector_table_base, {1'b0, pick[4:0]});
        end
        // withdrawn for one cycle after an ack so the taken source is not re-offered
        if (take)
            next_s.offer.valid = 1'b0;
        else
            next_s.offer = cand;

        if (!rst_n)
        begin
            next_s = '0;
            next_s.sync1 = 4'hF;
            next_s.sync2 = 4'hF;
            next_s.ext_prev = 2'h3;
            next_s.level = {ICV_NUM_SRC{ICV_LEVEL_RESET}};
            next_s.flags = ICV_FLAGS_RESET;
            next_s.saved = ICV_FLAGS_RESET;
            next_s.offer.kind = ICV_KIND_RESET;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        s <= next_s;
    end

    // =========================================================
    // outputs
    assign processor_flag_register = s.flags;
    assign request_bits = s.req;
    assign irq_valid = s.offer.valid;
    assign irq_kind = s.offer.kind;
    assign irq_num = s.offer.num;
    assign irq_level = s.offer.level;
    assign irq_vector = s.offer.vector;

endmodule : icv_unit

// File: sim/icv_unit_props.sv
/*
  icv_props: concurrent checks on the offer, flag and request outputs of icv_unit.
  assumes one ref_clk domain and synchronous active-low rst_n; bound below.
*/
module icv_props
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // state and offer
    input wire logic [19:0] vector_table_base,
    input wire icv_pkg::icv_flags_t processor_flag_register,
    input wire logic [31:0] request_bits,
    input wire logic irq_valid,
    input wire logic irq_ack,
    input wire icv_pkg::icv_kind_t irq_kind,
    input wire logic [5:0] irq_num,
    input wire logic [2:0] irq_level,
    input wire logic [19:0] irq_vector
);
    timeunit 1ns;
    timeprecision 1ps;
    import icv_pkg::*;
    // =========================================================
    // helper logic
    logic [2:0] ipl_want;
    logic [19:0] fix_vec;
    always_comb
    begin
        case (irq_kind)
            ICV_KIND_UNDEF: fix_vec = ICV_VEC_UNDEF;
            ICV_KIND_OVF: fix_vec = ICV_VEC_OVF;
            ICV_KIND_AMATCH: fix_vec = ICV_VEC_AMATCH;
            ICV_KIND_STEP: fix_vec = ICV_VEC_STEP;
            ICV_KIND_WDT: fix_vec = ICV_VEC_WDT;
            ICV_KIND_DBG: fix_vec = ICV_VEC_DBG;
            default: fix_vec = ICV_VEC_RESET;
        endcase
    end
    always_ff @(posedge ref_clk)
    begin
        ipl_want <= (irq_kind == ICV_KIND_MASKABLE) ? irq_level : (irq_kind == ICV_KIND_WDT) ? ICV_IPL_WDT :
            (irq_kind == ICV_KIND_RESET) ? ICV_IPL_RESET : processor_flag_register.processor_priority_level;
    end
    // =========================================================
    // properties
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_accept;
        irq_valid && irq_ack;
    endsequence
    sequence s_mask_offer;
        irq_valid && irq_kind == ICV_KIND_MASKABLE;
    endsequence
    property p_ack_drop;
        s_accept |=> !irq_valid;
    endproperty
    a_ack_drop: assert property (p_ack_drop) else $error("offer held after acceptance");
    // offer is registered, so it answers to last cycle's flags
    property p_mask_gate;
        s_mask_offer |-> $past(processor_flag_register.i) && irq_level > $past(processor_flag_register.processor_priority_level);
    endproperty
    a_mask_gate: assert property (p_mask_gate) else $error("maskable offer not eligible");
    property p_rel_vec;
        irq_valid && irq_kind inside {ICV_KIND_MASKABLE, ICV_KIND_SWINT}
            |-> irq_vector == vector_table_base + {12'h000, irq_num, 2'b00};
    endproperty
    a_rel_vec: assert property (p_rel_vec) else $error("relocatable vector wrong");
    property p_fixed_vec;
        irq_valid && !(irq_kind inside {ICV_KIND_MASKABLE, ICV_KIND_SWINT, ICV_KIND_BRK}) |-> irq_vector == fix_vec;
    endproperty
    a_fixed_vec: assert property (p_fixed_vec) else $error("fixed vector wrong");
    property p_ipl_load;
        s_accept |=> processor_flag_register.processor_priority_level == ipl_want;
    endproperty
    a_ipl_load: assert property (p_ipl_load) else $error("priority level not loaded");
    property p_flag_clear;
        s_accept ##0 !(irq_kind == ICV_KIND_SWINT && irq_num[5])
            |=> !processor_flag_register.i && !processor_flag_register.d && !processor_flag_register.u;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flags not cleared on acceptance");
    property p_u_keep;
        s_accept ##0 (irq_kind == ICV_KIND_SWINT && irq_num[5]) |=> $stable(processor_flag_register.u);
    endproperty
    a_u_keep: assert property (p_u_keep) else $error("stack select moved for high number");
    property p_req_clear;
        s_mask_offer ##0 irq_ack |=> !request_bits[$past(irq_num[4:0])];
    endproperty
    a_req_clear: assert property (p_req_clear) else $error("request bit kept after acceptance");
endmodule : icv_props

bind icv_unit icv_props i_props (.ref_clk, .rst_n, .vector_table_base, .processor_flag_register, .request_bits,
    .irq_valid, .irq_ack, .irq_kind, .irq_num, .irq_level, .irq_vector);

// File: sim/icv_cpu_model.sv
/*
  icv_cpu_model: cpu core stand-in that takes offered interrupts.
  assumes irq_valid is registered on ref_clk and stands until acknowledged.
*/
module icv_cpu_model
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // offer handshake; hold sets how slow the answer is
    input wire logic irq_valid,
    input wire logic [3:0] hold,
    output logic irq_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    int wait_n = 0;
    // a slow answer mimics a core still finishing its instruction
    always @(posedge ref_clk)
    begin
        #1;
        if (!rst_n || irq_valid !== 1'b1 || irq_ack)
        begin
            irq_ack = 1'b0;
            wait_n = 0;
        end
        else if (wait_n >= hold)
            irq_ack = 1'b1;
        else
            wait_n++;
    end
endmodule : icv_cpu_model

// File: sim/icv_unit_bench.sv
/*
  icv_unit_bench: self-checking bench for icv_unit with a cpu model on the offer side.
  assumes icv_pkg, icv_unit, icv_props and icv_cpu_model are compiled first.
*/
module icv_unit_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import icv_pkg::*;
    logic ref_clk = 0, rst_n = 0, reset_pin_n, key_input_pin_n, ext_pin_irq_0, ext_pin_irq_1;
    logic watchdog_evt, debugger_break_irq, instr_done, undefined_opcode_instr, ovf_trap_instr, overflow_flag;
    logic break_instr, sw_int_instr, return_instr, fetch_valid, fetch_first_byte, match_enable;
    logic flag_wr, ctl_wr, ctl_req, irq_valid, irq_ack;
    logic [1:0] ext_edge_rising;
    logic [2:0] ctl_level, irq_level, lv;
    logic [3:0] hold;
    logic [4:0] ctl_num;
    logic [5:0] sw_int_num, irq_num;
    logic [19:0] fetch_addr, match_addr, vector_table_base, irq_vector;
    logic [31:0] break_vector_word, request_bits;
    icv_periph_evt_t periph_evt;
    icv_flags_t flag_wdata, processor_flag_register;
    icv_kind_t irq_kind;
    icv_offer_t exp_q[$];
    icv_offer_t got, want;
    int num_errors = 0, n_tests = 0, cycles = 0, seed = 91124;
    int pos[14] = '{0, 10, 9, 8, 7, 6, 5, 2, 3, 4, 0, 1, 0, 0};
    logic [4:0] nums[14] = '{ICV_NUM_KEY, ICV_NUM_ADC, ICV_NUM_S0_TX, ICV_NUM_S0_RX, ICV_NUM_S1_TX,
        ICV_NUM_S1_RX, ICV_NUM_TA0, ICV_NUM_TX0, ICV_NUM_TX1, ICV_NUM_TX2, ICV_NUM_TB0, ICV_NUM_TB1,
        ICV_NUM_EXT0, ICV_NUM_EXT1};
    icv_kind_t sk[8] = '{ICV_KIND_UNDEF, ICV_KIND_OVF, ICV_KIND_BRK, ICV_KIND_BRK, ICV_KIND_WDT,
        ICV_KIND_DBG, ICV_KIND_STEP, ICV_KIND_AMATCH};
    logic [5:0] swn[6] = '{6'h00, 6'h1F, 6'h20, 6'h3F, 6'h05, 6'h2A};
    logic [19:0] sv[8];

    icv_unit i_dut (.*);
    icv_cpu_model i_cpu (.ref_clk, .rst_n, .irq_valid, .hold, .irq_ack);

    // =========================================================
    // clock, timeout, report
    always #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            close_out();
        end
    end
    task automatic close_out;
        $display("tests %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : close_out
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // =========================================================
    // monitor: every acceptance must match the oldest note
    always @(posedge ref_clk)
    begin
        if (rst_n && irq_valid === 1'b1 && irq_ack === 1'b1)
        begin
            got = '{1'b1, irq_kind, irq_num, irq_level, irq_vector};
            want = (exp_q.size() != 0) ? exp_q.pop_front() : '1;
            got.valid = want.valid;
            check(got, want);
        end
    end
    // =========================================================
    // driver tasks
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : step
    task automatic note(input logic full, input icv_kind_t k, input logic [5:0] n, input logic [2:0] l);
        exp_q.push_back('{full, k, (full || k == ICV_KIND_SWINT) ? n : 6'h00, l, (k == ICV_KIND_SWINT || full) ?
            vector_table_base + {12'h000, n, 2'b00} : sv[0]});
    endtask : note
    task automatic set_flags(input logic [2:0] p, input logic u, input logic i, input logic d);
        flag_wdata = '{p, u, i, d};
        flag_wr = 1;
        step(1);
        flag_wr = 0;
    endtask : set_flags
    task automatic ctl(input logic [4:0] n, input logic [2:0] l, input logic r);
        {ctl_num, ctl_level, ctl_req, ctl_wr} = {n, l, r, 1'b1};
        step(1);
        ctl_wr = 0;
        // idle cycle keeps back-to-back writes from re-raising the strobe at once
        step(1);
    endtask : ctl
    task automatic drain;
        int k = 0;
        while (exp_q.size() != 0 && k < 60)
        begin
            step(1);
            k++;
        end
        if (exp_q.size() != 0)
            check(34'(exp_q.size()), 34'h0);
        exp_q.delete();
        step(4);
        hold = 4'($random(seed) & 3);
    endtask : drain
    // =========================================================
    // main sequence
    initial
    begin
        {reset_pin_n, key_input_pin_n, watchdog_evt, debugger_break_irq, instr_done} = 5'b11000;
        {undefined_opcode_instr, ovf_trap_instr, overflow_flag, break_instr, sw_int_instr} = '0;
        {return_instr, fetch_valid, fetch_first_byte, match_enable, flag_wr, ctl_wr, ctl_req} = '0;
        {ctl_num, ctl_level, sw_int_num, flag_wdata, periph_evt, fetch_addr, hold} = '0;
        ext_edge_rising = 2'($random(seed));
        {ext_pin_irq_1, ext_pin_irq_0} = ~ext_edge_rising;
        vector_table_base = 20'($random(seed)) & 20'hF_FF00;
        match_addr = 20'($random(seed));
        break_vector_word = 32'hFFFF_FFFF;
        sv = '{ICV_VEC_UNDEF, ICV_VEC_OVF, vector_table_base, ICV_VEC_BRK, ICV_VEC_WDT, ICV_VEC_DBG,
            ICV_VEC_STEP, ICV_VEC_AMATCH};
        step(2);
        rst_n = 1;
        step(1);
        note(0, ICV_KIND_RESET, 0, 0);
        exp_q[0].vector = ICV_VEC_RESET;
        reset_pin_n = 0;
        step(1);
        reset_pin_n = 1;
        drain();
        // every peripheral source at a random level
        for (int i = 0; i < 14; i++)
        begin
            lv = 3'($random(seed));
            if (lv == 0)
                lv = 3'h7;
            ctl(nums[i], lv, 1);
            set_flags(0, 0, 1, 0);
            note(1, ICV_KIND_MASKABLE, {1'b0, nums[i]}, lv);
            key_input_pin_n = (i != 0);
            ext_pin_irq_0 ^= (i == 12);
            ext_pin_irq_1 ^= (i == 13);
            periph_evt = (i inside {[1:11]}) ? icv_periph_evt_t'(11'h001 << pos[i]) : '0;
            step(1);
            {key_input_pin_n, periph_evt} = {1'b1, 11'h000};
            drain();
        end
        // the opposite edge on the pins must stay quiet
        {ext_pin_irq_1, ext_pin_irq_0} = ~ext_edge_rising;
        step(6);
        check(request_bits, 0);
        // tie at one level, gating by processor level, level zero
        ctl(ICV_NUM_S0_TX, 5, 1);
        ctl(ICV_NUM_TA0, 5, 1);
        ctl(ICV_NUM_ADC, 0, 1);
        periph_evt = icv_periph_evt_t'(11'h620);
        step(1);
        periph_evt = '0;
        step(3);
        check(request_bits, 32'h0022_4000);
        set_flags(5, 0, 1, 0);
        step(8);
        note(1, ICV_KIND_MASKABLE, 6'h11, 5);
        set_flags(4, 0, 1, 0);
        drain();
        note(1, ICV_KIND_MASKABLE, 6'h15, 5);
        set_flags(4, 0, 1, 0);
        drain();
        check(request_bits, 32'h0000_4000);
        ctl(ICV_NUM_ADC, 0, 0);
        step(1);
        check(request_bits, 0);
        // non-maskable specials with maskables shut off
        for (int j = 0; j < 8; j++)
        begin
            set_flags(7, 0, 0, j == 6);
            note(0, sk[j], 0, 0);
            exp_q[0].vector = sv[j];
            {overflow_flag, fetch_addr, match_enable} = {1'b1, match_addr, 1'b1};
            break_vector_word = (j == 3) ? 32'h0001_2344 : 32'hFFFF_FFFF;
            {undefined_opcode_instr, ovf_trap_instr, break_instr} = {j == 0, j == 1, j == 2 || j == 3};
            {watchdog_evt, debugger_break_irq, instr_done} = {j == 4, j == 5, j == 6};
            {fetch_valid, fetch_first_byte} = {2{j == 7}};
            step(1);
            {undefined_opcode_instr, ovf_trap_instr, break_instr, watchdog_evt} = '0;
            {debugger_break_irq, instr_done, fetch_valid, fetch_first_byte} = '0;
            drain();
        end
        // clear overflow flag, mid-instruction match, step with debug flag clear
        {overflow_flag, ovf_trap_instr, instr_done, fetch_valid, fetch_first_byte} = 5'b01110;
        step(1);
        {ovf_trap_instr, instr_done, fetch_valid} = '0;
        step(8);
        // numbered software interrupts and return
        for (int k = 0; k < 6; k++)
        begin
            set_flags(2, 1, 0, 0);
            note(0, ICV_KIND_SWINT, swn[k], 0);
            {sw_int_instr, sw_int_num} = {1'b1, swn[k]};
            step(1);
            sw_int_instr = 0;
            drain();
            return_instr = 1;
            step(1);
            return_instr = 0;
            check(processor_flag_register, 6'b010_100);
        end
        close_out();
    end
endmodule : icv_unit_bench
